/* File: hdl/pmc_pkg.sv */
/*
  Package for the packet handler and mode controller: register indices,
  field positions, reset values, mode codes and timing constants.
  Assumes a 125 MHz core clock.
*/
package pmc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_FIFO_SIZE_THRESHOLD = 4'h0;
  localparam logic [3:0] ADDR_PAYLOAD_LENGTH = 4'h1;
  localparam logic [3:0] ADDR_NODE_ADDRESS = 4'h2;
  localparam logic [3:0] ADDR_PACKET_FORMAT = 4'h3;
  localparam logic [3:0] ADDR_CRC_FILTER_ACCESS = 4'h4;
  localparam logic [3:0] ADDR_OPERATING_MODE = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_FIFO_DATA = 4'h7;

  // Reset values
  localparam logic [7:0] RST_FIFO_SIZE_THRESHOLD = 8'h0f;
  localparam logic [7:0] RST_PAYLOAD_LENGTH = 8'h0f;
  localparam logic [7:0] RST_NODE_ADDRESS = 8'h00;
  localparam logic [7:0] RST_PACKET_FORMAT = 8'h00;
  localparam logic [7:0] RST_CRC_FILTER_ACCESS = 8'h00;
  localparam logic [7:0] RST_OPERATING_MODE = 8'h20;

  // Field positions
  localparam int FIFO_SIZE_HI = 7;
  localparam int FIFO_SIZE_LO = 6;
  localparam int THRESH_HI = 5;
  localparam int MANCHESTER_BIT = 7;
  localparam int LENGTH_HI = 6;
  localparam int FORMAT_VAR_BIT = 7;
  localparam int PREAMBLE_HI = 6;
  localparam int PREAMBLE_LO = 5;
  localparam int SCRAMBLE_BIT = 4;
  localparam int CRC_EN_BIT = 3;
  localparam int ADDR_FILT_HI = 2;
  localparam int ADDR_FILT_LO = 1;
  localparam int CRC_OK_BIT = 0;
  localparam int CRC_KEEP_BIT = 7;
  localparam int FIFO_READ_BIT = 6;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam int IRQA_SEL_HI = 7;
  localparam int IRQA_SEL_LO = 6;

  // Operating mode codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_RECEIVE = 3'h3;
  localparam logic [2:0] MODE_TRANSMIT = 3'h4;

  // Address filter codes
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_NODE = 2'h1;
  localparam logic [1:0] FILT_NODE_00 = 2'h2;
  localparam logic [1:0] FILT_NODE_00_ff = 2'h3;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hff;

  // FIFO geometry: capacity is (size code + 1) * 16 bytes
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_STEP = 7'h10;

  // Timing
  localparam int CLK_MHZ = 125;
  localparam int XTAL_START_US = 5000;
  localparam int PLL_LOCK_US = 500;
  localparam int XTAL_START_CYC = XTAL_START_US * CLK_MHZ;
  localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
endpackage

/* File: hdl/pmc_sync.sv */
/*
  Two-flop synchroniser for single-bit levels from outside the clock domain.
  Assumes an asynchronous active-low reset already synchronised.
*/
`timescale 1ns/1ps
module pmc_sync
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Active-low reset
  input wire logic din, // Asynchronous level
  output logic dout // Synchronised level
);
  logic meta;

  // First flop feeds only the second one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* File: hdl/pmc_packet_handler.sv */
/*
  Packet handler and operating mode controller: register file, 64-byte
  FIFO, threshold flags, receive filters and mode timing.
  Assumes a serial link from the demodulator clocked by link_clk (sampled
  here, not a second domain) and a host on the plain register port.
*/
// Function
// - Threshold equals six-bit field plus one
// - Receive threshold flag when count at/above
// - Transmit threshold flag when count at/below
// - Manchester coding enabled by payload bit 7
// - Length field: fixed size or maximum; code uses it only as the variable-format maximum
// - Variable format drops overlong length byte
// - Eight-bit node address register
// - Format bit 7 selects variable length
// - Preamble code gives one to four bytes
// - Format bit 4 enables scrambling
// - Format bit 3 enables CRC
// - Address filter modes accept node/broadcasts
// - Format bit 0 reports last CRC good
// - CRC error clears FIFO unless kept
// - Standby access bit selects write/read
// - Not-empty and full indications provided
// - Three-bit mode field decode
// - Crystal running within 5 ms
// - PLL lock within 0.5 ms, output
// - Sleep disables buffered clock output
// - FIFO size code selects 16..64 bytes
// - First interrupt select routes four sources
`timescale 1ns/1ps
module pmc_packet_handler
(
  input wire logic clk, // Core clock, 125 MHz
  input wire logic resetn, // Asynchronous active-low reset
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic link_clk, // Received bit clock from demodulator
  input wire logic link_data, // Received bit, MSB first
  input wire logic link_frame, // High across a received packet
  input wire logic link_crc_ok, // CRC verdict at end of frame
  input wire logic ref_clk_in, // Buffered clock source
  output logic clk_out, // Buffered clock to host, gated in sleep
  output logic pll_lock, // PLL lock status
  output logic xtal_ready, // Crystal oscillator running
  output logic rx_thresh_irq, // Receive threshold level
  output logic tx_thresh_irq, // Transmit threshold level
  output logic queue_not_empty_n, // Low when FIFO empty
  output logic queue_full_flag, // FIFO holds its capacity
  output logic host_irq_a, // First interrupt line
  output logic manchester_en, // Manchester coding enable
  output logic scramble_en, // Scrambling enable
  output logic crc_en, // CRC enable
  output logic [2:0] preamble_bytes, // Preamble length minus one
  output logic [2:0] op_mode // Decoded operating mode code
);
  logic rst_s1;
  logic rst_n;
  logic [7:0] fifo_size_threshold;
  logic [7:0] payload_length_config;
  logic [7:0] node_address_config;
  logic [7:0] packet_format_config;
  logic [7:0] crc_filter_fifo_access;
  logic [7:0] operating_mode_config;
  logic [7:0] irq_route_config;
  logic crc_good;
  logic [7:0] mem [0:pmc_pkg::FIFO_DEPTH-1];
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic [6:0] count;
  logic [6:0] capacity;
  logic [6:0] threshold;
  logic lclk_s;
  logic ldat_s;
  logic lfrm_s;
  logic lcrc_s;
  logic lclk_d;
  logic lfrm_d;
  logic bit_tick;
  logic frame_end;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [7:0] byte_idx;
  logic drop;
  logic byte_done;
  logic [7:0] rx_byte;
  logic rx_push;
  logic host_push;
  logic host_pop;
  logic fifo_clear;
  logic addr_ok;
  logic len_ok;
  logic data_rdy;
  logic byte_pulse;
  logic [2:0] prev_mode;
  logic [31:0] timer;

  // Reset released through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Link pins come from another domain
  pmc_sync u_sync_clk (.clk(clk), .rst_n(rst_n), .din(link_clk), .dout(lclk_s));
  pmc_sync u_sync_dat (.clk(clk), .rst_n(rst_n), .din(link_data), .dout(ldat_s));
  pmc_sync u_sync_frm (.clk(clk), .rst_n(rst_n), .din(link_frame), .dout(lfrm_s));
  pmc_sync u_sync_crc (.clk(clk), .rst_n(rst_n), .din(link_crc_ok), .dout(lcrc_s));

  // Configuration registers; CRC result bit is hardware-owned
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_size_threshold <= pmc_pkg::RST_FIFO_SIZE_THRESHOLD;
      payload_length_config <= pmc_pkg::RST_PAYLOAD_LENGTH;
      node_address_config <= pmc_pkg::RST_NODE_ADDRESS;
      packet_format_config <= pmc_pkg::RST_PACKET_FORMAT;
      crc_filter_fifo_access <= pmc_pkg::RST_CRC_FILTER_ACCESS;
      operating_mode_config <= pmc_pkg::RST_OPERATING_MODE;
      irq_route_config <= 8'h00;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        pmc_pkg::ADDR_FIFO_SIZE_THRESHOLD: fifo_size_threshold <= reg_wdata;
        pmc_pkg::ADDR_PAYLOAD_LENGTH: payload_length_config <= reg_wdata;
        pmc_pkg::ADDR_NODE_ADDRESS: node_address_config <= reg_wdata;
        pmc_pkg::ADDR_PACKET_FORMAT: packet_format_config <= reg_wdata;
        pmc_pkg::ADDR_CRC_FILTER_ACCESS: crc_filter_fifo_access <= reg_wdata;
        pmc_pkg::ADDR_OPERATING_MODE: operating_mode_config <= reg_wdata;
        pmc_pkg::ADDR_STATUS: irq_route_config <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Mode-facing configuration outputs
  assign manchester_en = payload_length_config[pmc_pkg::MANCHESTER_BIT];
  assign scramble_en = packet_format_config[pmc_pkg::SCRAMBLE_BIT];
  assign crc_en = packet_format_config[pmc_pkg::CRC_EN_BIT];
  // Code 00..11 means one to four bytes; output is bytes minus one
  assign preamble_bytes = {1'b0, packet_format_config[pmc_pkg::PREAMBLE_HI:pmc_pkg::PREAMBLE_LO]};
  assign op_mode = operating_mode_config[pmc_pkg::MODE_HI:pmc_pkg::MODE_LO];

  // Capacity and threshold
  assign capacity = 7'(({5'h0, fifo_size_threshold[pmc_pkg::FIFO_SIZE_HI:pmc_pkg::FIFO_SIZE_LO]} + 7'h1)
                       * pmc_pkg::FIFO_STEP);
  assign threshold = {1'b0, fifo_size_threshold[pmc_pkg::THRESH_HI:0]} + 7'h1;

  // Link edge detection on synchronised copies
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lclk_d <= 1'b0;
      lfrm_d <= 1'b0;
    end
    else
    begin
      lclk_d <= lclk_s;
      lfrm_d <= lfrm_s;
    end
  end
  assign bit_tick = lclk_s & ~lclk_d & lfrm_s & (op_mode == pmc_pkg::MODE_RECEIVE);
  assign frame_end = lfrm_d & ~lfrm_s & (op_mode == pmc_pkg::MODE_RECEIVE);

  // Byte assembly and packet acceptance
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      byte_idx <= 8'h00;
      drop <= 1'b0;
    end
    else if (!lfrm_s)
    begin
      bitcnt <= 3'h0;
      byte_idx <= 8'h00;
      drop <= 1'b0;
    end
    else if (bit_tick)
    begin
      shreg <= {shreg[6:0], ldat_s};
      bitcnt <= bitcnt + 3'h1;
      if (bitcnt == 3'h7)
      begin
        byte_idx <= byte_idx + 8'h1;
        if (!addr_ok || !len_ok)
          drop <= 1'b1;
      end
    end
  end
  assign byte_done = bit_tick & (bitcnt == 3'h7);
  assign rx_byte = {shreg[6:0], ldat_s};

  // Variable format: byte 0 is length, byte 1 address; fixed: byte 0 address
  always_comb
  begin
    len_ok = 1'b1;
    addr_ok = 1'b1;
    if (packet_format_config[pmc_pkg::FORMAT_VAR_BIT] && byte_idx == 8'h00)
      len_ok = rx_byte[6:0] <= payload_length_config[pmc_pkg::LENGTH_HI:0] && !rx_byte[7];
    if (byte_idx == {7'h0, packet_format_config[pmc_pkg::FORMAT_VAR_BIT]})
    begin
      unique case (packet_format_config[pmc_pkg::ADDR_FILT_HI:pmc_pkg::ADDR_FILT_LO])
        pmc_pkg::FILT_NONE: addr_ok = 1'b1;
        pmc_pkg::FILT_NODE: addr_ok = rx_byte == node_address_config;
        pmc_pkg::FILT_NODE_00: addr_ok = rx_byte == node_address_config || rx_byte == pmc_pkg::BCAST_ZERO;
        pmc_pkg::FILT_NODE_00_ff: addr_ok = rx_byte == node_address_config || rx_byte == pmc_pkg::BCAST_ZERO
                                            || rx_byte == pmc_pkg::BCAST_ONES;
      endcase
    end
  end

  // FIFO traffic; dropped packets stop filling and get flushed
  assign rx_push = byte_done & ~drop & addr_ok & len_ok & (count < capacity);
  assign host_push = reg_wr & (reg_addr == pmc_pkg::ADDR_FIFO_DATA) & (count < capacity)
                     & (op_mode == pmc_pkg::MODE_STANDBY) & ~crc_filter_fifo_access[pmc_pkg::FIFO_READ_BIT];
  assign host_pop = reg_rd & (reg_addr == pmc_pkg::ADDR_FIFO_DATA) & (count != 7'h0)
                    & (op_mode == pmc_pkg::MODE_STANDBY) & crc_filter_fifo_access[pmc_pkg::FIFO_READ_BIT];
  assign fifo_clear = frame_end & (drop | (crc_en & ~lcrc_s & ~crc_filter_fifo_access[pmc_pkg::CRC_KEEP_BIT]));

  // Byte storage addressed by write pointer
  always_ff @(posedge clk)
  begin
    if (rx_push)
      mem[wr_ptr] <= rx_byte;
    else if (host_push)
      mem[wr_ptr] <= reg_wdata;
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 6'h0;
      rd_ptr <= 6'h0;
      count <= 7'h0;
    end
    else if (fifo_clear)
    begin
      wr_ptr <= 6'h0;
      rd_ptr <= 6'h0;
      count <= 7'h0;
    end
    else
    begin
      if (rx_push || host_push)
        wr_ptr <= wr_ptr + 6'h1;
      if (host_pop)
        rd_ptr <= rd_ptr + 6'h1;
      count <= count + 7'((rx_push || host_push) ? 1 : 0) - 7'(host_pop ? 1 : 0);
    end
  end

  // CRC result and data-ready; new verdict wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_good <= 1'b0;
      data_rdy <= 1'b0;
      byte_pulse <= 1'b0;
    end
    else
    begin
      byte_pulse <= rx_push;
      if (frame_end && crc_en)
        crc_good <= lcrc_s;
      if (frame_end && !drop && (!crc_en || lcrc_s))
        data_rdy <= 1'b1;
      else if (op_mode != pmc_pkg::MODE_RECEIVE)
        data_rdy <= 1'b0;
    end
  end

  // Level flags recomputed every cycle
  assign rx_thresh_irq = (op_mode == pmc_pkg::MODE_RECEIVE) && (count >= threshold);
  assign tx_thresh_irq = count <= threshold;
  assign queue_not_empty_n = count != 7'h0;
  assign queue_full_flag = count >= capacity;

  // First interrupt line routing in receive
  always_comb
  begin
    unique case (irq_route_config[pmc_pkg::IRQA_SEL_HI:pmc_pkg::IRQA_SEL_LO])
      2'h0: host_irq_a = data_rdy;
      2'h1: host_irq_a = byte_pulse;
      2'h2: host_irq_a = queue_not_empty_n;
      2'h3: host_irq_a = lfrm_s & ~drop;
    endcase
  end

  // Mode transition timing; a fresh mode restarts the timer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_mode <= pmc_pkg::MODE_STANDBY;
      timer <= 32'h0;
      xtal_ready <= 1'b0;
      pll_lock <= 1'b0;
    end
    else
    begin
      prev_mode <= op_mode;
      if (op_mode != prev_mode)
        timer <= 32'h0;
      else if (timer != 32'hffffffff)
        timer <= timer + 32'h1;
      if (op_mode == pmc_pkg::MODE_SLEEP)
        xtal_ready <= 1'b0;
      else if (!xtal_ready && timer >= 32'(pmc_pkg::XTAL_START_CYC - 1))
        xtal_ready <= 1'b1;
      if (op_mode == pmc_pkg::MODE_SLEEP || op_mode == pmc_pkg::MODE_STANDBY)
        pll_lock <= 1'b0;
      else if (xtal_ready && timer >= 32'(pmc_pkg::PLL_LOCK_CYC - 1))
        pll_lock <= 1'b1;
    end
  end

  // Clock gated off in sleep; host may lose its clock here
  assign clk_out = ref_clk_in & (op_mode != pmc_pkg::MODE_SLEEP);

  // Register read port, data one cycle after strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        pmc_pkg::ADDR_FIFO_SIZE_THRESHOLD: reg_rdata <= fifo_size_threshold;
        pmc_pkg::ADDR_PAYLOAD_LENGTH: reg_rdata <= payload_length_config;
        pmc_pkg::ADDR_NODE_ADDRESS: reg_rdata <= node_address_config;
        pmc_pkg::ADDR_PACKET_FORMAT: reg_rdata <= {packet_format_config[7:1], crc_good};
        pmc_pkg::ADDR_CRC_FILTER_ACCESS: reg_rdata <= crc_filter_fifo_access;
        pmc_pkg::ADDR_OPERATING_MODE: reg_rdata <= operating_mode_config;
        pmc_pkg::ADDR_STATUS: reg_rdata <= irq_route_config;
        pmc_pkg::ADDR_FIFO_DATA: reg_rdata <= host_pop ? mem[rd_ptr] : 8'h00;
        default: reg_rdata <= {1'b0, count}; // Unmapped indices show occupancy
      endcase
    end
  end

  // Threshold flag tracks occupancy in the same cycle
  a_rx_thresh_level: assert property (@(posedge clk) disable iff (!rst_n)
    (op_mode == pmc_pkg::MODE_RECEIVE && count >= threshold) |-> rx_thresh_irq)
    else $error("rx threshold flag missing");
  a_tx_thresh_level: assert property (@(posedge clk) disable iff (!rst_n)
    (count == threshold + 7'h1) |-> !tx_thresh_irq)
    else $error("tx threshold flag above threshold");
  a_thresh_plus_one: assert property (@(posedge clk) disable iff (!rst_n)
    threshold == {1'b0, fifo_size_threshold[5:0]} + 7'h1)
    else $error("threshold not field plus one");
  a_crc_clear_fifo: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && crc_en && !lcrc_s && !crc_filter_fifo_access[7]) |=> count == 7'h0)
    else $error("fifo not cleared on crc error");
  a_crc_result_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && crc_en) |=> crc_good == $past(lcrc_s))
    else $error("crc result not recorded");
  a_sleep_clk_off: assert property (@(posedge clk) disable iff (!rst_n)
    (op_mode == pmc_pkg::MODE_SLEEP) |-> !clk_out)
    else $error("clock out active in sleep");
  a_read_blocks_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (crc_filter_fifo_access[6] && !rx_push && !host_pop && !fifo_clear) |=> count == $past(count))
    else $error("fifo written while read selected");
  a_full_flag: assert property (@(posedge clk) disable iff (!rst_n)
    queue_full_flag |=> count <= $past(count))
    else $error("full fifo still filled");
  a_sleep_no_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (op_mode == pmc_pkg::MODE_SLEEP) |=> !xtal_ready && !pll_lock)
    else $error("oscillator flags in sleep");
endmodule

/* File: dv/pmc_link_model.sv */
/*
  Behavioural model of the demodulator side of the receive link: sends
  one frame of whole bytes, MSB first, with a bit clock of 64 ns.
  Assumes the bench calls send only while no other frame is running.
*/
`timescale 1ns/1ps
module pmc_link_model
(
  output logic link_clk, // Bit clock, still outside frames
  output logic link_data, // Serial bit
  output logic link_frame, // High across the payload
  output logic link_crc_ok // CRC verdict, stable at frame end
);
  initial
  begin
    link_clk = 1'b0;
    link_data = 1'b1;
    link_frame = 1'b0;
    link_crc_ok = 1'b0;
  end

  // One frame; the bit is set while the clock is low, taken on its rise
  task automatic send(input logic [7:0] b [5], input int n, input logic ok);
    link_crc_ok = ok;
    link_frame = 1'b1;
    for (int i = 0; i < n; i++)
      for (int j = 7; j >= 0; j--)
      begin
        link_data = b[i][j];
        #32 link_clk = 1'b1;
        #32 link_clk = 1'b0;
      end
    // Give the sampler time to take the last bit before the frame ends
    #64 link_frame = 1'b0;
    // A released line shows no stale value; the verdict outlives the frame
    link_data = ~link_data;
    #64 link_crc_ok = ~ok;
  endtask
endmodule

/* File: dv/test_packet_handler_mode_ctrl.sv */
/*
  Self-checking bench for the packet handler: register table, FIFO access,
  threshold flags, receive filters, CRC handling and mode decode.
  Assumes the 8 ns core clock and the link model beside the design.
*/
`timescale 1ns/1ps
module test_packet_handler_mode_ctrl;
  typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e; logic [2:0] f;} pmc_row_s;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ref_clk_in = 1'b0;
  logic [7:0] reg_rdata;
  logic link_clk, link_data, link_frame, link_crc_ok;
  logic clk_out, pll_lock, xtal_ready, rx_thresh_irq, tx_thresh_irq;
  logic queue_not_empty_n, queue_full_flag, host_irq_a, manchester_en, scramble_en, crc_en;
  logic [2:0] preamble_bytes, op_mode;
  logic [7:0] d, c, c0;
  logic [7:0] pk [5];
  logic [7:0] exp_cnt;
  logic [7:0] addrs [4] = '{8'h33, 8'h00, 8'hff, 8'h5a};
  logic [7:0] rst_v [7] = '{pmc_pkg::RST_FIFO_SIZE_THRESHOLD, pmc_pkg::RST_PAYLOAD_LENGTH,
    pmc_pkg::RST_NODE_ADDRESS, pmc_pkg::RST_PACKET_FORMAT, pmc_pkg::RST_CRC_FILTER_ACCESS,
    pmc_pkg::RST_OPERATING_MODE, 8'h00};
  // Register rows: index, write, readback, {manchester, scramble, crc}
  pmc_row_s rows [7] = '{'{4'h0, 8'hc5, 8'hc5, 3'h0}, '{4'h1, 8'h85, 8'h85, 3'h4},
    '{4'h2, 8'h5a, 8'h5a, 3'h4}, '{4'h3, 8'hff, 8'hfe, 3'h7}, '{4'h4, 8'hc0, 8'hc0, 3'h7},
    '{4'h6, 8'h40, 8'h40, 3'h7}, '{4'h9, 8'hff, 8'h00, 3'h7}};
  logic acc;
  int bad_count = 0;
  int num_checks = 0;

  initial
  begin
    forever #4 clk = ~clk;
  end

  // Unrelated free-running source; offset so it never moves on a sample point
  initial
  begin
    #0.5;
    forever #9 ref_clk_in = ~ref_clk_in;
  end

  pmc_packet_handler dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .link_data(link_data), .link_frame(link_frame), .link_crc_ok(link_crc_ok),
    .ref_clk_in(ref_clk_in), .clk_out(clk_out), .pll_lock(pll_lock), .xtal_ready(xtal_ready),
    .rx_thresh_irq(rx_thresh_irq), .tx_thresh_irq(tx_thresh_irq),
    .queue_not_empty_n(queue_not_empty_n), .queue_full_flag(queue_full_flag),
    .host_irq_a(host_irq_a), .manchester_en(manchester_en), .scramble_en(scramble_en),
    .crc_en(crc_en), .preamble_bytes(preamble_bytes), .op_mode(op_mode));

  pmc_link_model link (.link_clk(link_clk), .link_data(link_data), .link_frame(link_frame),
    .link_crc_ok(link_crc_ok));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data is taken in the cycle after the strobe, and only there
  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask

  // Hold reset, then let the two-flop release settle before any request
  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic frame(input logic [7:0] b0, b1, b2, b3, b4, input int n, input logic ok);
    pk = '{b0, b1, b2, b3, b4};
    link.send(pk, n, ok);
    repeat (12) @(posedge clk);
  endtask

  task automatic summarize();
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of under 100 us
  initial
  begin
    #400000;
    bad_count++;
    summarize();
  end

  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk8(d, rows[i].e);
      chk8({5'h0, manchester_en, scramble_en, crc_en}, {5'h0, rows[i].f});
    end
    // Second reset in mid-run restores the table
    do_reset();
    foreach (rst_v[i])
    begin
      rd(i[3:0], d);
      chk8(d, rst_v[i]);
    end
    chk8({5'h0, op_mode}, {5'h0, pmc_pkg::MODE_STANDBY});
    chk1(tx_thresh_irq, 1'b1);
    chk1(queue_not_empty_n, 1'b0);
    // Preamble codes and mode codes
    for (int p = 0; p < 4; p++)
    begin
      wr(pmc_pkg::ADDR_PACKET_FORMAT, {1'b0, p[1:0], 5'h0});
      chk8({5'h0, preamble_bytes}, p[7:0]);
    end
    for (int m = 0; m < 5; m++)
    begin
      wr(pmc_pkg::ADDR_OPERATING_MODE, {m[2:0], 5'h0});
      chk8({5'h0, op_mode}, m[7:0]);
      repeat (8)
      begin
        @(posedge clk);
        #1 chk1(clk_out, (m == 0) ? 1'b0 : ref_clk_in);
      end
    end
    // FIFO of 16 bytes, threshold field 2: filled until it refuses
    wr(pmc_pkg::ADDR_OPERATING_MODE, 8'h20);
    wr(pmc_pkg::ADDR_FIFO_SIZE_THRESHOLD, 8'h02);
    for (int i = 0; i < 17; i++)
    begin
      wr(pmc_pkg::ADDR_FIFO_DATA, 8'ha0 + i[7:0]);
      exp_cnt = (i < 16) ? i[7:0] + 8'h01 : 8'h10;
      rd(4'h8, c);
      chk8(c, exp_cnt);
      chk1(tx_thresh_irq, exp_cnt <= 8'h03);
      chk1(queue_full_flag, exp_cnt == 8'h10);
      chk1(queue_not_empty_n, 1'b1);
    end
    // Drained in order, then an empty read gives zero
    wr(pmc_pkg::ADDR_CRC_FILTER_ACCESS, 8'h40);
    for (int i = 0; i < 17; i++)
    begin
      rd(pmc_pkg::ADDR_FIFO_DATA, d);
      chk8(d, (i < 16) ? 8'ha0 + i[7:0] : 8'h00);
    end
    chk1(queue_not_empty_n, 1'b0);
    // Receive: 64 bytes, threshold 6, first line shows not-empty
    wr(pmc_pkg::ADDR_FIFO_SIZE_THRESHOLD, 8'hc5);
    wr(pmc_pkg::ADDR_NODE_ADDRESS, 8'h5a);
    wr(4'h6, 8'h80);
    wr(pmc_pkg::ADDR_CRC_FILTER_ACCESS, 8'h80);
    wr(pmc_pkg::ADDR_OPERATING_MODE, 8'h40);
    chk1(pll_lock, 1'b0);
    wr(pmc_pkg::ADDR_OPERATING_MODE, 8'h60);
    exp_cnt = 8'h00;
    for (int f = 0; f < 4; f++)
    begin
      wr(pmc_pkg::ADDR_PACKET_FORMAT, {5'h0, f[1:0], 1'b0});
      foreach (addrs[k])
      begin
        frame(addrs[k], 8'h11, 8'h22, 8'h00, 8'h00, 3, 1'b1);
        acc = (f == 0) || (addrs[k] == 8'h5a) || (f >= 2 && addrs[k] == 8'h00) || (f == 3 && addrs[k] == 8'hff);
        // A rejected packet flushes the whole FIFO at frame end
        exp_cnt = acc ? exp_cnt + 8'h03 : 8'h00;
        rd(4'h8, c);
        chk8(c, exp_cnt);
        chk1(rx_thresh_irq, exp_cnt >= 8'h06);
        chk1(tx_thresh_irq, exp_cnt <= 8'h06);
        chk1(host_irq_a, exp_cnt != 8'h00);
      end
    end
    // CRC error flushes the FIFO unless kept
    wr(pmc_pkg::ADDR_CRC_FILTER_ACCESS, 8'h00);
    wr(pmc_pkg::ADDR_PACKET_FORMAT, 8'h08);
    frame(8'h5a, 8'h01, 8'h02, 8'h00, 8'h00, 3, 1'b0);
    rd(4'h8, c);
    chk8(c, 8'h00);
    rd(pmc_pkg::ADDR_PACKET_FORMAT, d);
    chk8(d, 8'h08);
    frame(8'h5a, 8'h01, 8'h02, 8'h00, 8'h00, 3, 1'b1);
    rd(pmc_pkg::ADDR_PACKET_FORMAT, d);
    chk8(d, 8'h09);
    wr(pmc_pkg::ADDR_CRC_FILTER_ACCESS, 8'h80);
    frame(8'h5a, 8'h01, 8'h02, 8'h00, 8'h00, 3, 1'b0);
    rd(4'h8, c);
    chk8(c, 8'h06);
    // Variable format, maximum 3: one above the limit drops, the limit passes
    wr(pmc_pkg::ADDR_PAYLOAD_LENGTH, 8'h03);
    wr(pmc_pkg::ADDR_PACKET_FORMAT, 8'h80);
    frame(8'h04, 8'h5a, 8'h01, 8'h02, 8'h03, 5, 1'b1);
    rd(4'h8, c);
    chk8(c, 8'h00);
    frame(8'h03, 8'h5a, 8'h01, 8'h02, 8'h00, 4, 1'b1);
    rd(4'h8, c0);
    chk8(c0, 8'h04);
    // First line on data-ready, dropped once receive is left
    wr(4'h6, 8'h00);
    chk1(host_irq_a, 1'b1);
    wr(pmc_pkg::ADDR_OPERATING_MODE, 8'h20);
    @(posedge clk);
    #1 chk1(host_irq_a, 1'b0);
    summarize();
  end
endmodule
